//--- shared/spcbs_consts.svh
`ifndef SPCBS_CONSTS_SVH
`define SPCBS_CONSTS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define SPCBS_A_CTRL   5'h00
`define SPCBS_A_DATA   5'h04
`define SPCBS_A_PWR    5'h08
`define SPCBS_A_T2     5'h0c
`define SPCBS_A_BRG    5'h10
`define SPCBS_A_IST    5'h14
`define SPCBS_A_IMSK   5'h18
`define SPCBS_A_BIT    5'h1c

// ****************************************
// Field positions and reset values
// ****************************************
`define SPCBS_B_MODE_LO 7
`define SPCBS_B_MODE_HI 6
`define SPCBS_B_MPF     5
`define SPCBS_B_REN     4
`define SPCBS_B_TX9     3
`define SPCBS_B_RX9     2
`define SPCBS_B_TXF     1
`define SPCBS_B_RXF     0
`define SPCBS_B_DBL     7
`define SPCBS_B_T2TX    5
`define SPCBS_B_T2RX    4
`define SPCBS_B_BRGTX   3
`define SPCBS_B_BRGRX   2
`define SPCBS_I_TX      0
`define SPCBS_I_RX      1
`define SPCBS_REG_RST   8'h00

// ****************************************
// Timing counts
// ****************************************
`define SPCBS_PRE_LAST  4'hb
`define SPCBS_PRE_HALF  4'h6
`define SPCBS_OVS_LAST  4'hf
`define SPCBS_OVS_MID   4'h7
`define SPCBS_BITS_M0   4'h8
`define SPCBS_BITS_M0TX 4'h9
`define SPCBS_BITS_M1   4'ha
`define SPCBS_BITS_M9   4'hb
`define SPCBS_RX_BITS   4'h9
`define SPCBS_RX_BITS9  4'ha

`endif

//--- shared/spcbs_pkg.sv
package spcbs_pkg;

  // Serial mode, in the order of the two select bits
  typedef enum logic [1:0] {SPCBS_SHIFT, SPCBS_UART8, SPCBS_UART9F, SPCBS_UART9V} spcbs_mode_t;

  // Transmitter and receiver states
  typedef enum logic {SPCBS_TX_IDLE, SPCBS_TX_SEND} spcbs_tx_st_t;
  typedef enum logic [1:0] {SPCBS_RX_IDLE, SPCBS_RX_START, SPCBS_RX_DATA} spcbs_rx_st_t;

endpackage

//--- shared/spcbs_tick_if.sv
`timescale 1ns/1ps

// Rate tick and mode for one direction
interface spcbs_tick_if;
  logic                   tick;
  spcbs_pkg::spcbs_mode_t mode;
  modport src (output tick, output mode);
  modport dst (input tick, input mode);
endinterface // spcbs_tick_if

//--- hw/spcbs_tx.sv
`timescale 1ns/1ps
`include "spcbs_consts.svh"

module spcbs_tx (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clk_en,
  spcbs_tick_if.dst       tk,
  input  wire logic       i_start,
  input  wire logic [7:0] i_data,
  input  wire logic       i_ninth,
  output logic            o_busy,
  output logic            o_line,
  output logic            o_done
);
  spcbs_pkg::spcbs_tx_st_t st_reg, st_next;
  logic [10:0]             sh_reg, sh_next;
  logic [3:0]              bits_reg, bits_next;
  logic [3:0]              sub_reg, sub_next;
  logic                    shift0;
  logic                    bit_end;

  assign shift0  = (tk.mode == spcbs_pkg::SPCBS_SHIFT);
  assign bit_end = (st_reg == spcbs_pkg::SPCBS_TX_SEND) & tk.tick & (shift0 | (sub_reg == `SPCBS_OVS_LAST));
  assign o_busy  = (st_reg == spcbs_pkg::SPCBS_TX_SEND);
  assign o_line  = sh_reg[0];
  // [R8] end of 8th bit or stop start
  assign o_done  = bit_end & (bits_reg == (shift0 ? 4'h1 : 4'h2));

  // Frame load and bit shifting
  always_comb begin
    st_next   = st_reg;
    sh_next   = sh_reg;
    bits_next = bits_reg;
    sub_next  = sub_reg;
    case (st_reg)
      spcbs_pkg::SPCBS_TX_IDLE: begin
        if (i_start) begin
          st_next  = spcbs_pkg::SPCBS_TX_SEND;
          sub_next = 4'h0;
          case (tk.mode)
            // Leading idle slot aligns the first bit to a tick
            spcbs_pkg::SPCBS_SHIFT: begin
              sh_next   = {2'h3, i_data, 1'b1};
              bits_next = `SPCBS_BITS_M0TX;
            end
            // [R2] start, data, stop
            spcbs_pkg::SPCBS_UART8: begin
              sh_next   = {2'h3, i_data, 1'b0};
              bits_next = `SPCBS_BITS_M1;
            end
            // [R3] [R6] ninth bit sent
            default: begin
              sh_next   = {1'b1, i_ninth, i_data, 1'b0};
              bits_next = `SPCBS_BITS_M9;
            end
          endcase
        end
      end
      spcbs_pkg::SPCBS_TX_SEND: begin
        if (bit_end) begin
          sh_next   = {1'b1, sh_reg[10:1]};
          bits_next = bits_reg - 4'h1;
          sub_next  = 4'h0;
          if (bits_reg == 4'h1) begin
            st_next = spcbs_pkg::SPCBS_TX_IDLE;
          end
        end else if (tk.tick) begin
          sub_next = sub_reg + 4'h1;
        end
      end
      default: st_next = spcbs_pkg::SPCBS_TX_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg   <= spcbs_pkg::SPCBS_TX_IDLE;
      sh_reg   <= 11'h7ff;
      bits_reg <= 4'h0;
      sub_reg  <= 4'h0;
    end else if (i_clk_en) begin
      st_reg   <= st_next;
      sh_reg   <= sh_next;
      bits_reg <= bits_next;
      sub_reg  <= sub_next;
    end
  end
endmodule // spcbs_tx

//--- hw/spcbs_rx.sv
`timescale 1ns/1ps
`include "spcbs_consts.svh"

module spcbs_rx (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clk_en,
  spcbs_tick_if.dst       tk,
  input  wire logic       i_go,
  input  wire logic       i_line,
  output logic            o_active,
  output logic [7:0]      o_data,
  output logic            o_ninth,
  output logic            o_done
);
  spcbs_pkg::spcbs_rx_st_t st_reg, st_next;
  logic [8:0]              sh_reg, sh_next;
  logic [3:0]              cnt_reg, cnt_next;
  logic [3:0]              sub_reg, sub_next;
  logic                    done_reg, done_next;
  logic                    shift0;
  logic                    stop9;
  logic                    bit_end;

  assign shift0   = (tk.mode == spcbs_pkg::SPCBS_SHIFT);
  assign stop9    = (tk.mode == spcbs_pkg::SPCBS_UART9F) | (tk.mode == spcbs_pkg::SPCBS_UART9V);
  assign bit_end  = tk.tick & (shift0 | (sub_reg == `SPCBS_OVS_LAST));
  assign o_active = (st_reg != spcbs_pkg::SPCBS_RX_IDLE);
  assign o_data   = shift0 ? sh_reg[8:1] : sh_reg[7:0];
  assign o_ninth  = sh_reg[8];
  assign o_done   = done_reg;

  // Start detection and bit sampling
  always_comb begin
    st_next   = st_reg;
    sh_next   = sh_reg;
    cnt_next  = cnt_reg;
    sub_next  = sub_reg;
    done_next = 1'b0;
    case (st_reg)
      // [R4] start only while allowed
      spcbs_pkg::SPCBS_RX_IDLE: begin
        if (i_go & tk.tick) begin
          sub_next = 4'h0;
          if (shift0) begin
            st_next  = spcbs_pkg::SPCBS_RX_DATA;
            cnt_next = `SPCBS_BITS_M0;
          end else if (!i_line) begin
            st_next = spcbs_pkg::SPCBS_RX_START;
          end
        end
      end
      spcbs_pkg::SPCBS_RX_START: begin
        if (tk.tick) begin
          sub_next = sub_reg + 4'h1;
          if (sub_reg == `SPCBS_OVS_MID) begin
            sub_next = 4'h0;
            cnt_next = stop9 ? `SPCBS_RX_BITS9 : `SPCBS_RX_BITS;
            st_next  = i_line ? spcbs_pkg::SPCBS_RX_IDLE : spcbs_pkg::SPCBS_RX_DATA;
          end
        end
      end
      // [R2] [R3] data then ninth or stop
      spcbs_pkg::SPCBS_RX_DATA: begin
        if (bit_end) begin
          // Stop bit of 9-bit frames awaited, not kept
          if (!(stop9 & (cnt_reg == 4'h1))) begin
            sh_next = {i_line, sh_reg[8:1]};
          end
          cnt_next = cnt_reg - 4'h1;
          sub_next = 4'h0;
          if (cnt_reg == 4'h1) begin
            st_next   = spcbs_pkg::SPCBS_RX_IDLE;
            done_next = 1'b1;
          end
        end else if (tk.tick) begin
          sub_next = sub_reg + 4'h1;
        end
      end
      default: st_next = spcbs_pkg::SPCBS_RX_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg   <= spcbs_pkg::SPCBS_RX_IDLE;
      sh_reg   <= 9'h000;
      cnt_reg  <= 4'h0;
      sub_reg  <= 4'h0;
      done_reg <= 1'b0;
    end else if (i_clk_en) begin
      st_reg   <= st_next;
      sh_reg   <= sh_next;
      cnt_reg  <= cnt_next;
      sub_reg  <= sub_next;
      done_reg <= done_next;
    end
  end
endmodule // spcbs_rx

//--- hw/spcbs_top.sv
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "spcbs_consts.svh"

// Operation
// [R1] Select bits 00,01,10,11 give shift, 8-bit, 9-bit fixed, 9-bit variable modes.
// [R2] 8-bit mode frame: start 0, eight data LSB first, stop 1; stop kept.
// [R3] 9-bit modes add programmable ninth bit; receiver keeps ninth, ignores stop.
// [R4] Asynchronous reception starts on a start bit only while reception allowed.
// [R5] Multiprocessor filter bit enables address filtering in 9-bit modes.
// [R6] Transmitter sends the stored ninth bit value in 9-bit modes.
// [R7] Receive ninth field loads the received ninth bit; unused in shift mode.
// [R8] Transmit flag sets after 8th bit in shift mode, else at stop start.
// [R9] Receive flag sets after 8th bit in shift mode; software clears it.
// [R10] Serial control resets to zero and each bit is writable alone.
// [R11] Shift mode rate is fixed, independent of timers and rate generator.
// [R12] Fixed 9-bit mode runs at clock/64, or clock/32 with doubling.
// [R13] Variable modes default to timer 1 overflow as rate source.
// [R14] Transmit and receive may use different timers, so rates differ.
// [R15] Transmit source: rate generator, else timer 2, else timer 1.
// [R16] Receive source: rate generator, else timer 2, else timer 1.

module spcbs_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_clk_en,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_t1_ovf,
  input  wire logic        i_t2_ovf,
  input  wire logic        i_brg_ovf,
  input  wire logic        i_rxd,
  output logic             o_rxd,
  output logic             o_rxd_oe_n,
  output logic             o_txd,
  output logic             o_irq
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]             ctrl_reg, ctrl_next;
  logic [7:0]             pwr_reg, pwr_next;
  logic [7:0]             t2_reg, t2_next;
  logic [7:0]             brg_reg, brg_next;
  logic [7:0]             rxbuf_reg, rxbuf_next;
  logic [1:0]             ist_reg, ist_next;
  logic [1:0]             imsk_reg, imsk_next;
  logic                   irq_reg, irq_next;
  logic                   wait_reg, wait_next;
  logic [31:0]            rdata_reg, rdata_next;
  logic [3:0]             pre_reg, pre_next;
  logic                   txtk_reg, txtk_next;
  logic                   rxtk_reg, rxtk_next;
  logic                   txd_reg, txd_next;
  logic                   rxo_reg, rxo_next;
  logic                   oe_n_reg, oe_n_next;
  logic                   m0_sync_reg, m0_sync_next;
  spcbs_pkg::spcbs_mode_t mode;
  logic                   req;
  logic                   wr;
  logic                   rd;
  logic                   tx_start;
  logic                   tx_busy;
  logic                   tx_line;
  logic                   tx_done;
  logic                   rx_go;
  logic                   rx_active;
  logic [7:0]             rx_data;
  logic                   rx_ninth;
  logic                   rx_done;
  logic                   rx_ok;
  logic                   m0_tk;
  logic                   m2_tk;

  spcbs_tick_if tx_tk ();
  spcbs_tick_if rx_tk ();

  // ****************************************
  // Decode helpers
  // ****************************************

  // Address match against a register offset
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction

  // Rate source pick for one direction
  function automatic logic pick(input logic brg_sel, input logic t2_sel,
                                input logic brg, input logic t2, input logic t1);
    return brg_sel ? brg : (t2_sel ? t2 : t1);
  endfunction

  // [R1] mode from the two select bits
  assign mode = spcbs_pkg::spcbs_mode_t'({ctrl_reg[`SPCBS_B_MODE_LO], ctrl_reg[`SPCBS_B_MODE_HI]});

  // Bus request qualifiers
  assign req      = i_avs_read | i_avs_write;
  assign wr       = i_avs_write & ~wait_reg;
  assign rd       = i_avs_read & ~wait_reg;
  assign tx_start = wr & hit(i_avs_address, `SPCBS_A_DATA) & ~tx_busy;

  // [R9] shift mode receive waits for clear flag
  assign rx_go = ctrl_reg[`SPCBS_B_REN] & ((mode != spcbs_pkg::SPCBS_SHIFT) | ~ctrl_reg[`SPCBS_B_RXF]);

  // [R5] filter drops frames with ninth bit low
  assign rx_ok = rx_done & ~ctrl_reg[`SPCBS_B_RXF]
               & ((mode == spcbs_pkg::SPCBS_SHIFT) | ~ctrl_reg[`SPCBS_B_MPF] | rx_ninth);

  // ****************************************
  // Transmitter and receiver
  // ****************************************
  assign tx_tk.tick = txtk_reg;
  assign tx_tk.mode = mode;
  assign rx_tk.tick = rxtk_reg;
  assign rx_tk.mode = mode;

  spcbs_tx i_spcbs_tx (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .tk        (tx_tk),
    .i_start   (tx_start),
    .i_data    (i_avs_writedata[7:0]),
    .i_ninth   (ctrl_reg[`SPCBS_B_TX9]),
    .o_busy    (tx_busy),
    .o_line    (tx_line),
    .o_done    (tx_done)
  );

  spcbs_rx i_spcbs_rx (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .tk        (rx_tk),
    .i_go      (rx_go),
    .i_line    (i_rxd),
    .o_active  (rx_active),
    .o_data    (rx_data),
    .o_ninth   (rx_ninth),
    .o_done    (rx_done)
  );

  // ****************************************
  // Bus slave
  // ****************************************

  // Wait one cycle, then answer
  always_comb begin
    wait_next  = ~(req & wait_reg);
    rdata_next = rdata_reg;
    if (i_avs_read & wait_reg) begin
      rdata_next = 32'h0000_0000;
      case (i_avs_address)
        `SPCBS_A_CTRL: rdata_next[7:0] = ctrl_reg;
        `SPCBS_A_DATA: rdata_next[7:0] = rxbuf_reg;
        `SPCBS_A_PWR:  rdata_next[7:0] = pwr_reg;
        `SPCBS_A_T2:   rdata_next[7:0] = t2_reg;
        `SPCBS_A_BRG:  rdata_next[7:0] = brg_reg;
        `SPCBS_A_IST:  rdata_next[1:0] = ist_reg;
        `SPCBS_A_IMSK: rdata_next[1:0] = imsk_reg;
        default:       rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (i_clk_en) begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Control, status and interrupt
  // ****************************************

  // Register writes, hardware sets last
  always_comb begin
    ctrl_next  = ctrl_reg;
    pwr_next   = pwr_reg;
    t2_next    = t2_reg;
    brg_next   = brg_reg;
    rxbuf_next = rxbuf_reg;
    ist_next   = ist_reg;
    imsk_next  = imsk_reg;
    if (wr & hit(i_avs_address, `SPCBS_A_CTRL)) begin
      ctrl_next = i_avs_writedata[7:0];
    end
    // [R10] single bit write
    if (wr & hit(i_avs_address, `SPCBS_A_BIT)) begin
      ctrl_next[i_avs_writedata[2:0]] = i_avs_writedata[3];
    end
    if (wr & hit(i_avs_address, `SPCBS_A_PWR)) begin
      pwr_next = i_avs_writedata[7:0];
    end
    if (wr & hit(i_avs_address, `SPCBS_A_T2)) begin
      t2_next = i_avs_writedata[7:0];
    end
    if (wr & hit(i_avs_address, `SPCBS_A_BRG)) begin
      brg_next = i_avs_writedata[7:0];
    end
    if (wr & hit(i_avs_address, `SPCBS_A_IMSK)) begin
      imsk_next = i_avs_writedata[1:0];
    end
    // Status read clears only the bits it returned
    if (rd & hit(i_avs_address, `SPCBS_A_IST)) begin
      ist_next = ist_reg & ~rdata_reg[1:0];
    end
    // [R8] transmit flag set
    if (tx_done) begin
      ctrl_next[`SPCBS_B_TXF] = 1'b1;
      ist_next[`SPCBS_I_TX]   = 1'b1;
    end
    // [R9] receive flag set
    if (rx_ok) begin
      ctrl_next[`SPCBS_B_RXF] = 1'b1;
      ist_next[`SPCBS_I_RX]   = 1'b1;
      rxbuf_next              = rx_data;
      // [R7] ninth bit stored
      if (mode != spcbs_pkg::SPCBS_SHIFT) begin
        ctrl_next[`SPCBS_B_RX9] = rx_ninth;
      end
    end
    irq_next = |(ist_next & imsk_next);
  end

  // [R10] control clears on reset
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg  <= `SPCBS_REG_RST;
      pwr_reg   <= `SPCBS_REG_RST;
      t2_reg    <= `SPCBS_REG_RST;
      brg_reg   <= `SPCBS_REG_RST;
      rxbuf_reg <= `SPCBS_REG_RST;
      ist_reg   <= 2'h0;
      imsk_reg  <= 2'h0;
      irq_reg   <= 1'b0;
    end else if (i_clk_en) begin
      ctrl_reg  <= ctrl_next;
      pwr_reg   <= pwr_next;
      t2_reg    <= t2_next;
      brg_reg   <= brg_next;
      rxbuf_reg <= rxbuf_next;
      ist_reg   <= ist_next;
      imsk_reg  <= imsk_next;
      irq_reg   <= irq_next;
    end
  end

  // ****************************************
  // Rate ticks and pins
  // ****************************************

  // [R11] fixed divide by 12 for shift mode
  assign m0_tk = (pre_reg == `SPCBS_PRE_LAST);
  // [R12] 16 ticks per bit: /4 or /2
  assign m2_tk = pwr_reg[`SPCBS_B_DBL] ? pre_reg[0] : (pre_reg[1:0] == 2'h3);

  // Tick selection and line drive
  always_comb begin
    pre_next = m0_tk ? 4'h0 : pre_reg + 4'h1;
    case (mode)
      spcbs_pkg::SPCBS_SHIFT: begin
        txtk_next = m0_tk;
        rxtk_next = m0_tk;
      end
      spcbs_pkg::SPCBS_UART9F: begin
        txtk_next = m2_tk;
        rxtk_next = m2_tk;
      end
      // [R13] [R14] per direction source choice
      default: begin
        // [R15] transmit source
        txtk_next = pick(brg_reg[`SPCBS_B_BRGTX], t2_reg[`SPCBS_B_T2TX], i_brg_ovf, i_t2_ovf, i_t1_ovf);
        // [R16] receive source
        rxtk_next = pick(brg_reg[`SPCBS_B_BRGRX], t2_reg[`SPCBS_B_T2RX], i_brg_ovf, i_t2_ovf, i_t1_ovf);
      end
    endcase
    if (mode == spcbs_pkg::SPCBS_SHIFT) begin
      // Shift clock low six clocks per bit, once tick aligned
      txd_next  = ~((tx_busy & m0_sync_reg) | rx_active) | (pre_reg == 4'h0) | (pre_reg > `SPCBS_PRE_HALF);
      oe_n_next = ~tx_busy;
    end else begin
      txd_next  = tx_line;
      oe_n_next = 1'b1;
    end
    rxo_next = tx_line;
    // Transmit framed from its first tick on
    m0_sync_next = tx_busy & (m0_sync_reg | txtk_reg);
  end

  // Tick and pin registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_reg  <= 4'h0;
      txtk_reg <= 1'b0;
      rxtk_reg <= 1'b0;
      txd_reg  <= 1'b1;
      rxo_reg  <= 1'b1;
      oe_n_reg <= 1'b1;
      m0_sync_reg <= 1'b0;
    end else if (i_clk_en) begin
      pre_reg  <= pre_next;
      txtk_reg <= txtk_next;
      rxtk_reg <= rxtk_next;
      txd_reg  <= txd_next;
      rxo_reg  <= rxo_next;
      oe_n_reg <= oe_n_next;
      m0_sync_reg <= m0_sync_next;
    end
  end

  // Outputs straight from flops
  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_irq             = irq_reg;
  assign o_txd             = txd_reg;
  assign o_rxd             = rxo_reg;
  assign o_rxd_oe_n        = oe_n_reg;

endmodule // spcbs_top

//--- tb/spcbs_sva.sv
`timescale 1ns/1ps
`include "spcbs_consts.svh"

module spcbs_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_txd,
  input wire logic        o_irq
);
  logic req;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // Any bus strobe
  assign req = i_avs_read | i_avs_write;

  // ****************************************
  // Register bus
  // ****************************************
  property p_wait_one; req && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_wait_one:
    assert property (p_wait_one) else $error("no answer one cycle after request");
  property p_wait_pulse; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_wait_pulse:
    assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_wait_cause; $fell(o_avs_waitrequest) |-> $past(req); endproperty
  a_wait_cause:
    assert property (p_wait_cause) else $error("answer without request");
  property p_rd_hi_zero; i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000; endproperty
  a_rd_hi_zero:
    assert property (p_rd_hi_zero) else $error("upper read bits not zero");
  property p_rd_stable; !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata); endproperty
  a_rd_stable:
    assert property (p_rd_stable) else $error("read data moved without read");

  // ****************************************
  // Interrupt and line
  // ****************************************
  property p_mask_irq;
    i_avs_write && !o_avs_waitrequest && i_avs_address == `SPCBS_A_IMSK && i_avs_writedata[1:0] == 2'h0
      |-> ##2 !o_irq;
  endproperty
  a_mask_irq:
    assert property (p_mask_irq) else $error("irq high with all masked");
  property p_txd_low_min; $fell(o_txd) |-> !o_txd [*6]; endproperty
  a_txd_low_min:
    assert property (p_txd_low_min) else $error("txd low pulse too short");
  property p_txd_low_max; $fell(o_txd) |-> ##[1:1000] o_txd; endproperty
  a_txd_low_max:
    assert property (p_txd_low_max) else $error("txd stuck low");

  c_frame: cover property ($fell(o_txd));
  c_irq: cover property ($rose(o_irq));
  c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule // spcbs_sva

//--- tb/spcbs_remote.sv
`timescale 1ns/1ps

module spcbs_remote (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  initial o_line = 1'b1;

  task automatic send(input int p, input logic [10:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      o_line <= v[k];
      repeat (p) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask

  task automatic recv(input int p, output logic [9:0] v);
    @(negedge i_line);
    repeat (p / 2) @(posedge i_clk);
    for (int k = 0; k < 10; k++) begin
      repeat (p) @(posedge i_clk);
      v[k] = i_line;
    end
    repeat (p) @(posedge i_clk);
  endtask
endmodule // spcbs_remote

//--- tb/spcbs_top_tb.sv
`timescale 1ns/1ps
`include "spcbs_consts.svh"

module spcbs_top_tb;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [4:0]  i_avs_address = 5'h00;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest, o_rxd, o_rxd_oe_n, o_txd, o_irq, rxd_line;
  logic        i_t1_ovf = 1'b0, i_t2_ovf = 1'b0, i_brg_ovf = 1'b0;
  logic [9:0]  frame;
  int          errors = 0, cmp_count = 0, cyc = 0;
  wire logic   rxd_pin = o_rxd_oe_n ? rxd_line : o_rxd;

  always #25 i_sys_clk = ~i_sys_clk;

  spcbs_top i_spcbs_top (.i_sys_clk, .i_rst, .i_clk_en(1'b1), .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_t1_ovf, .i_t2_ovf, .i_brg_ovf,
    .i_rxd(rxd_pin), .o_rxd, .o_rxd_oe_n, .o_txd, .o_irq);
  spcbs_remote i_spcbs_remote (.i_clk(i_sys_clk), .i_line(o_txd), .o_line(rxd_line));

  // Overflow ticks: bit of 48, 80, 32 clocks; run ceiling
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    i_t1_ovf <= (cyc % 3 == 0);
    i_t2_ovf <= (cyc % 5 == 0);
    i_brg_ovf <= (cyc % 2 == 0);
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_sys_clk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(`SPCBS_A_CTRL, 32'h0);
    rd(`SPCBS_A_PWR, 32'h0);
    wr(`SPCBS_A_BIT, 32'hb);
    rd(`SPCBS_A_CTRL, 32'h8);
    $display("reset test done");
    wr(`SPCBS_A_CTRL, 32'h0);
    wr(`SPCBS_A_DATA, 32'h96);
    for (int k = 0; k < 8; k++) begin
      @(posedge o_txd);
      frame[k] = rxd_pin;
      chk({31'h0, o_rxd_oe_n}, 32'h0);
    end
    chk({24'h0, frame[7:0]}, 32'h96);
    repeat (8) @(posedge i_sys_clk);
    rd(`SPCBS_A_CTRL, 32'h2);
    rd(`SPCBS_A_IST, 32'h1);
    $display("mode 0 test done");
    wr(`SPCBS_A_IMSK, 32'h1);
    wr(`SPCBS_A_CTRL, 32'h88);
    wr(`SPCBS_A_DATA, 32'ha5);
    i_spcbs_remote.recv(64, frame);
    chk({22'h0, frame}, 32'h3a5);
    chk({31'h0, o_irq}, 32'h1);
    rd(`SPCBS_A_CTRL, 32'h8a);
    rd(`SPCBS_A_IST, 32'h1);
    rd(`SPCBS_A_IST, 32'h0);
    wr(`SPCBS_A_PWR, 32'h80);
    wr(`SPCBS_A_CTRL, 32'h80);
    wr(`SPCBS_A_DATA, 32'h3c);
    i_spcbs_remote.recv(32, frame);
    chk({22'h0, frame}, 32'h23c);
    wr(`SPCBS_A_IMSK, 32'h0);
    repeat (2) @(posedge i_sys_clk);
    chk({31'h0, o_irq}, 32'h0);
    $display("mode 2 test done");
    for (int k = 0; k < 3; k++) begin
      wr(`SPCBS_A_T2, k > 0 ? 32'h20 : 32'h0);
      wr(`SPCBS_A_BRG, k > 1 ? 32'h8 : 32'h0);
      wr(`SPCBS_A_CTRL, 32'hc8);
      wr(`SPCBS_A_DATA, 32'h5a);
      i_spcbs_remote.recv(k == 0 ? 48 : (k == 1 ? 80 : 32), frame);
      chk({22'h0, frame}, 32'h35a);
    end
    $display("transmit source test done");
    wr(`SPCBS_A_T2, 32'h10);
    wr(`SPCBS_A_BRG, 32'h4);
    wr(`SPCBS_A_CTRL, 32'h50);
    i_spcbs_remote.send(32, 11'h32c, 10);
    rd(`SPCBS_A_DATA, 32'h96);
    rd(`SPCBS_A_CTRL, 32'h55);
    i_spcbs_remote.send(32, 11'h222, 10);
    rd(`SPCBS_A_DATA, 32'h96);
    wr(`SPCBS_A_CTRL, 32'hf0);
    i_spcbs_remote.send(32, 11'h478, 11);
    rd(`SPCBS_A_DATA, 32'h96);
    i_spcbs_remote.send(32, 11'h678, 11);
    rd(`SPCBS_A_DATA, 32'h3c);
    rd(`SPCBS_A_CTRL, 32'hf5);
    wr(`SPCBS_A_CTRL, 32'hc0);
    i_spcbs_remote.send(32, 11'h702, 11);
    rd(`SPCBS_A_DATA, 32'h3c);
    rd(`SPCBS_A_CTRL, 32'hc0);
    $display("receive test done");
    give_verdict();
  end
endmodule // spcbs_top_tb

bind spcbs_top spcbs_sva i_spcbs_sva (.i_sys_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_txd, .o_irq);
